// [edge_event.v]
`timescale 1ns/1ps
// Detects rising and falling changes of a synchronised level
module edge_event (
	input wire ref_clk,
	input wire sys_rst,
	input wire enable,
	input wire level,
	output wire rise,
	output wire fall
);
	reg prev; // Level one cycle ago
	reg armed; // Prev holds a valid sample
	// Track the level every cycle; arm only after an enabled cycle
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			prev <= 1'b0;
			armed <= 1'b0;
		end else begin
			prev <= level;
			armed <= enable;
		end
	end
	assign rise = enable & armed & level & ~prev;
	assign fall = enable & armed & ~level & prev;
endmodule // edge_event

// [option_store.sv]
`timescale 1ns/1ps
// Option byte store answering load requests after a chosen delay
module option_store (
	input wire ref_clk,
	input wire opt_load_req,
	input wire [7:0] delay,
	input wire [7:0] stored,
	output reg opt_valid,
	output reg [7:0] opt_data
);
	logic [7:0] wait_cnt = 8'h00; // Cycles waited on this request
	initial opt_valid = 1'b0;
	initial opt_data = 8'h00;
	// Steady byte while valid, scrambled between loads
	always @(posedge ref_clk) begin
		if (!opt_load_req) begin
			wait_cnt <= 8'h00;
			opt_valid <= 1'b0;
			opt_data <= ~opt_data;
		end else if (wait_cnt < delay) begin
			wait_cnt <= wait_cnt + 8'h01;
		end else begin
			opt_valid <= 1'b1;
			opt_data <= stored;
		end
	end
endmodule // option_store

// [supply_chk.sv]
`timescale 1ns/1ps
// Port checker for the supply supervisor
module supply_chk (
	input wire ref_clk,
	input wire sys_rst,
	input wire por_above,
	input wire bor_above,
	input wire chip_reset,
	input wire opt_load_req,
	input wire [2:0] brownout_threshold,
	input wire brownout_enable,
	input wire [15:0] cpu_khz,
	input wire flash_wait_states,
	input wire hreadyout,
	input wire hresp
);
	logic [11:0] since; // Cycles since the last clock step
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// Counts the quiet time between clock steps
	always @(posedge ref_clk) begin
		if (sys_rst)
			since <= 12'hFFF;
		else if ($changed(cpu_khz))
			since <= 12'h000;
		else if (since != 12'hFFF)
			since <= since + 12'h001;
	end
	a_bus_okay: assert property (hreadyout && !hresp) else $error("bus stalled or error");
	a_por_holds: assert property ((!por_above)[*4] |=> chip_reset)
		else $error("reset released without supply");
	a_bor_holds: assert property ((brownout_enable && !bor_above)[*4] |=> chip_reset)
		else $error("reset released under brown-out");
	a_load_in_reset: assert property (opt_load_req |-> chip_reset)
		else $error("option load outside reset");
	a_bor_level: assert property (brownout_threshold <= 3'h4)
		else $error("brown-out level out of range");
	a_step_ratio: assert property ($changed(cpu_khz) |-> $past(cpu_khz) < 4 * cpu_khz)
		else $error("clock step too large");
	a_step_gap: assert property ($changed(cpu_khz) |-> since >= 12'h4E1)
		else $error("clock steps too close");
	a_clock_cap: assert property (cpu_khz <= 16'h7D00)
		else $error("clock above ceiling");
	a_ws_high: assert property ((cpu_khz > 16'h3E80)[*2] |-> flash_wait_states)
		else $error("fast clock without wait state");
	a_ws_low: assert property ((flash_wait_states && $stable(cpu_khz)) |-> cpu_khz > 16'h1F40)
		else $error("wait state at slow clock");
endmodule // supply_chk

bind supply_supervisor_reset supply_chk u_chk (.*);

// [supply_supervisor_map.vh]
`ifndef SUPPLY_SUPERVISOR_MAP_VH
`define SUPPLY_SUPERVISOR_MAP_VH
// Register byte offsets
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_IRQ_CLEAR 12'h008
`define REG_IRQ_ENABLE 12'h00C
`define REG_OPTION 12'h010
`define REG_CLOCK_CTRL 12'h014
`define REG_POLICY 12'h018
// Control fields
`define CTRL_MON_EN 0
`define CTRL_EDGE_FALL 1
`define CTRL_EDGE_RISE 2
`define CTRL_LEVEL_LSB 4
`define CTRL_LEVEL_MSB 6
`define CTRL_VREF_STOP_OFF 8
`define CTRL_RANGE_LSB 12
`define CTRL_RANGE_MSB 13
`define CTRL_RESET 32'h0000_1000
// Status / interrupt bit positions
`define EV_FALL 0
`define EV_RISE 1
`define EV_POLICY 2
`define EV_WIDTH 3
// Option byte fields
`define OPT_BOR_LEVEL_LSB 0
`define OPT_BOR_LEVEL_MSB 2
`define OPT_BOR_OFF 3
`define BOR_LEVEL_COUNT 5
`define MON_LEVEL_COUNT 7
// Voltage scaling ranges
`define RANGE_1 2'h1
`define RANGE_2 2'h2
`define RANGE_3 2'h3
// Frequency ceilings and wait-state limits in kHz
`define R1_MAX_KHZ 32000
`define R1_ZERO_WS_KHZ 16000
`define R2_MAX_KHZ 16000
`define R2_ZERO_WS_KHZ 8000
`define R3_MAX_KHZ 4200
// Timing, clock 250 MHz
`define CLK_MHZ 250
`define STEP_GAP_US 5
`define STEP_GAP_CYC (`STEP_GAP_US * `CLK_MHZ)
`define STARTUP_BOR_US 3300
`define STARTUP_NOBOR_US 1000
`define STEP_RATIO 4
`endif

// [supply_supervisor_reset.v]
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "supply_supervisor_map.vh"
// Function
// - Hold reset while supply under reset threshold
// - Start option loading above power-up threshold
// - Options confirm, retune or kill brown-out
// - Five brown-out threshold selections
// - Seven software-selected monitor threshold levels
// - Monitor interrupt on fall, rise, both
// - Reference off in Stop when configured
// - Range 1: 32 MHz, 1 ws above 16
// - Range 2: 16 MHz, 1 ws above 8
// - Range 3: 4.2 MHz, zero wait states
// - Start-up 3.3 ms with BOR, 1 ms without
module supply_supervisor_reset #(
	parameter STARTUP_BOR_CYC = `STARTUP_BOR_US * `CLK_MHZ,
	parameter STARTUP_NOBOR_CYC = `STARTUP_NOBOR_US * `CLK_MHZ
) (
	input wire ref_clk,
	input wire sys_rst,
	input wire por_above, // Supply above power-on/down threshold
	input wire bor_above, // Supply above selected brown-out level
	input wire bor_at_power_on, // Brown-out active at power-on (strap)
	input wire mon_below, // Supply below monitor threshold
	input wire low_supply, // Supply between 1.65 and 1.71 V
	input wire stop_mode, // Core is in Stop mode
	input wire opt_valid, // Option bytes delivered
	input wire [7:0] opt_data, // Option byte contents
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire hsel,
	input wire hready,
	input wire [31:0] hwdata,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	output reg chip_reset, // Internal reset to the chip
	output reg opt_load_req, // Request to option store
	output reg [2:0] brownout_threshold, // Selected brown-out level
	output reg brownout_enable, // Brown-out comparator enabled
	output reg mon_enable, // Monitor comparator powered
	output reg [2:0] supply_monitor_threshold, // Monitor level
	output reg internal_reference_voltage, // Reference on
	output reg [15:0] cpu_khz, // Applied processor clock
	output reg flash_wait_states, // Flash wait states
	output reg irq
);
	// Sequencer states
	localparam S_RESET = 2'h0;
	localparam S_STARTUP = 2'h1;
	localparam S_LOAD = 2'h2;
	localparam S_RUN = 2'h3;
	localparam [15:0] STEP_GAP = `STEP_GAP_CYC; // Cycles between clock steps

	wire [4:0] sync_in; // Pin levels before synchronising
	wire [4:0] sync_out; // Synchronised levels
	wire por_s = sync_out[0];
	wire bor_s = sync_out[1];
	wire mon_s = sync_out[2];
	wire low_s = sync_out[3];
	wire stop_s = sync_out[4];
	assign sync_in = {stop_mode, low_supply, mon_below, bor_above, por_above};
	sync_2ff #(.WIDTH(5)) u_sync (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.din(sync_in),
		.dout(sync_out)
	);
	reg [1:0] strap_sync; // Strap synchroniser
	reg [1:0] opt_v_sync; // Option valid synchroniser
	reg [7:0] opt_d1; // Option byte, first stage
	reg [7:0] opt_d2; // Option byte, second stage, lands with valid
	// Synchronise strap, option valid and option byte
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			strap_sync <= 2'h0;
			opt_v_sync <= 2'h0;
			opt_d1 <= 8'h00;
			opt_d2 <= 8'h00;
		end else begin
			strap_sync <= {strap_sync[0], bor_at_power_on};
			opt_v_sync <= {opt_v_sync[0], opt_valid};
			opt_d1 <= opt_data;
			opt_d2 <= opt_d1;
		end
	end

	reg [1:0] state;
	reg [31:0] count; // Start-up counter
	reg bor_off; // Brown-out disabled for good
	reg [31:0] ctrl;
	reg [`EV_WIDTH-1:0] status;
	reg [`EV_WIDTH-1:0] irq_en;
	reg [15:0] clock_req; // Requested processor clock in kHz
	reg [15:0] gap_cnt; // Cycles left before next step allowed
	reg step_pend;
	// Active reset threshold: brown-out unless disabled
	wire supply_ok = por_s & (bor_off | ~brownout_enable | bor_s);
	wire [1:0] range = ctrl[`CTRL_RANGE_MSB:`CTRL_RANGE_LSB];

	// Highest processor clock for a range
	function [15:0] range_max;
		input [1:0] r;
		begin
			case (r)
				`RANGE_1: range_max = 16'd`R1_MAX_KHZ;
				`RANGE_2: range_max = 16'd`R2_MAX_KHZ;
				default: range_max = 16'd`R3_MAX_KHZ;
			endcase
		end
	endfunction
	// Wait states for a clock in a range
	function ws_for;
		input [1:0] r;
		input [15:0] khz;
		begin
			case (r)
				`RANGE_1: ws_for = (khz > 16'd`R1_ZERO_WS_KHZ);
				`RANGE_2: ws_for = (khz > 16'd`R2_ZERO_WS_KHZ);
				default: ws_for = 1'b0;
			endcase
		end
	endfunction

	// Reset sequencer and option loading
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			state <= S_RESET;
			count <= 32'h0000_0000;
			chip_reset <= 1'b1;
			opt_load_req <= 1'b0;
			bor_off <= 1'b0;
			brownout_threshold <= 3'h0;
			brownout_enable <= 1'b0;
		end else if (!supply_ok && state != S_RESET) begin
			state <= S_RESET; // Supply dropped: back into reset
			chip_reset <= 1'b1;
			opt_load_req <= 1'b0;
		end else begin
			case (state)
				S_RESET: begin
					chip_reset <= 1'b1;
					if (por_s) begin
						brownout_enable <= strap_sync[1] & ~bor_off;
						count <= strap_sync[1] ? STARTUP_BOR_CYC : STARTUP_NOBOR_CYC;
						state <= S_STARTUP;
					end
				end
				S_STARTUP: begin
					if (count == 32'h0000_0000) begin
						opt_load_req <= 1'b1;
						state <= S_LOAD;
					end else begin
						count <= count - 32'h0000_0001;
					end
				end
				S_LOAD: begin
					if (opt_v_sync[1]) begin
						opt_load_req <= 1'b0;
						if (opt_d2[`OPT_BOR_OFF]) begin
							bor_off <= 1'b1; // Permanent disable
							brownout_enable <= 1'b0;
						end else begin
							brownout_enable <= 1'b1;
						end
						// Out of range selections clamp to the top
						if (opt_d2[`OPT_BOR_LEVEL_MSB:`OPT_BOR_LEVEL_LSB] >= 3'd`BOR_LEVEL_COUNT)
							brownout_threshold <= 3'd`BOR_LEVEL_COUNT - 3'h1;
						else
							brownout_threshold <= opt_d2[`OPT_BOR_LEVEL_MSB:`OPT_BOR_LEVEL_LSB];
						chip_reset <= 1'b0;
						state <= S_RUN;
					end
				end
				default: begin
					chip_reset <= 1'b0;
				end
			endcase
		end
	end

	// Monitor edges, only while enabled
	wire mon_rise; // Supply went below threshold
	wire mon_fall; // Supply went back above
	edge_event u_edge (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.enable(ctrl[`CTRL_MON_EN]),
		.level(mon_s),
		.rise(mon_rise),
		.fall(mon_fall)
	);

	// AHB-Lite address phase capture
	reg ph_wr; // Pending write
	reg ph_rd; // Pending read
	reg [11:0] ph_addr;
	wire take = hsel & hready & htrans[1];
	wire wr_ctrl = ph_wr && ph_addr == `REG_CTRL;
	wire wr_clr = ph_wr && ph_addr == `REG_IRQ_CLEAR;
	wire wr_en = ph_wr && ph_addr == `REG_IRQ_ENABLE;
	wire wr_clk = ph_wr && ph_addr == `REG_CLOCK_CTRL;
	// Events from the monitor and the clock policy
	wire ev_fall = mon_rise & ctrl[`CTRL_EDGE_FALL];
	wire ev_rise = mon_fall & ctrl[`CTRL_EDGE_RISE];
	reg ev_policy;
	wire [`EV_WIDTH-1:0] ev = {ev_policy, ev_rise, ev_fall};
	wire [`EV_WIDTH-1:0] clr = wr_clr ? hwdata[`EV_WIDTH-1:0] : {`EV_WIDTH{1'b0}};

	// Bus registers and sticky status; set beats clear
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			ph_wr <= 1'b0;
			ph_rd <= 1'b0;
			ph_addr <= 12'h000;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			ctrl <= `CTRL_RESET;
			status <= {`EV_WIDTH{1'b0}};
			irq_en <= {`EV_WIDTH{1'b0}};
			irq <= 1'b0;
		end else begin
			ph_wr <= take & hwrite;
			ph_rd <= take & ~hwrite;
			if (take)
				ph_addr <= haddr[11:0];
			status <= (status & ~clr) | ev;
			irq <= |(((status & ~clr) | ev) & irq_en);
			if (wr_en)
				irq_en <= hwdata[`EV_WIDTH-1:0];
			if (wr_ctrl) begin
				ctrl <= hwdata & 32'h0000_317F;
				// Low supply forbids Range 1
				if (low_s && hwdata[`CTRL_RANGE_MSB:`CTRL_RANGE_LSB] == `RANGE_1)
					ctrl[`CTRL_RANGE_MSB:`CTRL_RANGE_LSB] <= range;
				else if (hwdata[`CTRL_RANGE_MSB:`CTRL_RANGE_LSB] == 2'h0)
					ctrl[`CTRL_RANGE_MSB:`CTRL_RANGE_LSB] <= range;
			end
			// Read data for the next data phase
			if (take && !hwrite) begin
				case (haddr[11:0])
					`REG_CTRL: hrdata <= ctrl;
					`REG_STATUS: hrdata <= {28'h0000000, mon_s & ctrl[`CTRL_MON_EN],
						status};
					`REG_IRQ_ENABLE: hrdata <= {29'h0, irq_en};
					`REG_OPTION: hrdata <= {27'h0, bor_off, brownout_enable,
						brownout_threshold};
					`REG_CLOCK_CTRL: hrdata <= {16'h0000, cpu_khz};
					`REG_POLICY: hrdata <= {15'h0, step_pend, 15'h0, flash_wait_states};
					default: hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Monitor analog controls
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			mon_enable <= 1'b0;
			supply_monitor_threshold <= 3'h0;
			internal_reference_voltage <= 1'b1;
		end else begin
			mon_enable <= ctrl[`CTRL_MON_EN];
			// Seven levels; code seven clamps to six
			if (ctrl[`CTRL_LEVEL_MSB:`CTRL_LEVEL_LSB] >= 3'd`MON_LEVEL_COUNT)
				supply_monitor_threshold <= 3'd`MON_LEVEL_COUNT - 3'h1;
			else
				supply_monitor_threshold <= ctrl[`CTRL_LEVEL_MSB:`CTRL_LEVEL_LSB];
			internal_reference_voltage <= ~(stop_s & ctrl[`CTRL_VREF_STOP_OFF]);
		end
	end

	// Clock step pacing and wait state policy
	wire [17:0] req4 = {clock_req, 2'b00};
	wire step_ok = ({2'b00, cpu_khz} < req4) && (clock_req <= range_max(range));
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			clock_req <= 16'd`R3_MAX_KHZ;
			cpu_khz <= 16'd`R3_MAX_KHZ;
			gap_cnt <= 16'h0000;
			step_pend <= 1'b0;
			flash_wait_states <= 1'b0;
			ev_policy <= 1'b0;
		end else begin
			ev_policy <= 1'b0;
			if (gap_cnt != 16'h0000)
				gap_cnt <= gap_cnt - 16'h0001;
			if (wr_clk) begin
				clock_req <= hwdata[15:0];
				step_pend <= 1'b1;
			end else if (step_pend && gap_cnt == 16'h0000) begin
				step_pend <= 1'b0;
				if (step_ok) begin
					cpu_khz <= clock_req;
					gap_cnt <= STEP_GAP;
				end else begin
					ev_policy <= 1'b1; // Refused step
				end
			end else if (cpu_khz > range_max(range)) begin
				cpu_khz <= range_max(range); // Range lowered: clamp
				gap_cnt <= STEP_GAP;
			end
			flash_wait_states <= ws_for(range, cpu_khz);
		end
	end
endmodule // supply_supervisor_reset

// [sync_2ff.v]
`timescale 1ns/1ps
// Two-stage synchroniser for a vector of levels
module sync_2ff #(
	parameter WIDTH = 1
) (
	input wire ref_clk,
	input wire sys_rst,
	input wire [WIDTH-1:0] din,
	output reg [WIDTH-1:0] dout
);
	reg [WIDTH-1:0] stage1; // First stage, read only by the second
	// Two flops in series
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			stage1 <= {WIDTH{1'b0}};
			dout <= {WIDTH{1'b0}};
		end else begin
			stage1 <= din;
			dout <= stage1;
		end
	end
endmodule // sync_2ff

// [tb.sv]
`timescale 1ns/1ps
`include "supply_supervisor_map.vh"
// Self-checking bench for the supply supervisor
module tb;
	logic ref_clk, sys_rst, por_above, bor_above, mon_below, low_supply, stop_mode;
	logic opt_valid, opt_load_req, hwrite, hsel, hready, hreadyout, hresp, chip_reset;
	logic brownout_enable, mon_enable, internal_reference_voltage, flash_wait_states, irq;
	logic [7:0] opt_data, stored, dly;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rdata;
	logic [2:0] brownout_threshold, supply_monitor_threshold;
	logic [15:0] cpu_khz;
	logic strap; // Brown-out strap at power-on
	int n_fail = 0, checks_done = 0, cyc = 0, i;
	assign hready = hreadyout; // Single slave drives bus ready
	supply_supervisor_reset #(.STARTUP_BOR_CYC(20), .STARTUP_NOBOR_CYC(10)) dut (
		.bor_at_power_on(strap), .hsize(3'h2), .*);
	option_store far (.delay(dly), .*);
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// Cuts a hang short
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail = n_fail + 1;
			$display("unexpected at %0t: timeout", $time);
			final_report;
		end
	end
	task final_report;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// One single-word transfer, then a cycle for updates to land
	task bus(input [11:0] a, input w, input [31:0] d);
		haddr <= {20'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		hsel <= 1'b1;
		@(posedge ref_clk);
		while (!hready) @(posedge ref_clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge ref_clk);
		while (!hready) @(posedge ref_clk);
		rdata = hrdata;
		@(posedge ref_clk);
	endtask
	task tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	initial begin
		sys_rst = 1'b1;
		por_above = 1'b0;
		bor_above = 1'b1;
		mon_below = 1'b0;
		low_supply = 1'b0;
		stop_mode = 1'b0;
		htrans = 2'h0;
		hsel = 1'b0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		stored = 8'h07;
		strap = 1'b1;
		dly = 8'h01;
		tick(20);
		sys_rst <= 1'b0;
		tick(1);
		chk(chip_reset, 1);
		chk(cpu_khz, 16'h1068);
		bus(`REG_CTRL, 0, 0);
		chk(rdata, 32'h1000);
		por_above <= 1'b1;
		for (i = 0; i < 60 && !opt_load_req; i++) @(posedge ref_clk);
		chk(i >= 20 && i <= 26, 1);
		chk(chip_reset, 1);
		for (i = 0; i < 60 && chip_reset; i++) @(posedge ref_clk);
		tick(1);
		chk(brownout_threshold, 4);
		chk(brownout_enable, 1);
		$display("power-up done");
		stored <= 8'h0A;
		dly <= 8'h28;
		bor_above <= 1'b0;
		for (i = 0; i < 20 && !chip_reset; i++) @(posedge ref_clk);
		chk(chip_reset, 1);
		bor_above <= 1'b1;
		for (i = 0; i < 200 && chip_reset; i++) @(posedge ref_clk);
		tick(1);
		chk(brownout_enable, 0);
		bor_above <= 1'b0;
		tick(10);
		chk(chip_reset, 0);
		bor_above <= 1'b1;
		$display("brown-out done");
		bus(`REG_IRQ_ENABLE, 1, 32'h7);
		mon_below <= 1'b1;
		tick(6);
		bus(`REG_STATUS, 0, 0);
		chk(rdata, 0);
		chk(irq, 0);
		chk(mon_enable, 0);
		for (i = 0; i < 8; i++) begin
			bus(`REG_CTRL, 1, 32'h1007 | (i << 4));
			tick(1);
			chk(supply_monitor_threshold, (i < 7) ? i : 6);
			chk(mon_enable, 1);
		end
		tick(4);
		bus(`REG_IRQ_CLEAR, 1, 32'h7);
		mon_below <= 1'b0;
		tick(6);
		bus(`REG_STATUS, 0, 0);
		chk(rdata, 32'h2);
		chk(irq, 1);
		bus(`REG_IRQ_CLEAR, 1, 32'h2);
		mon_below <= 1'b1;
		tick(6);
		bus(`REG_STATUS, 0, 0);
		chk(rdata, 32'h9);
		bus(`REG_IRQ_ENABLE, 1, 0);
		tick(2);
		chk(irq, 0);
		bus(`REG_IRQ_CLEAR, 1, 32'h7);
		bus(`REG_STATUS, 0, 0);
		chk(rdata, 32'h8);
		bus(`REG_CTRL, 1, 32'h1100);
		stop_mode <= 1'b1;
		tick(6);
		chk(internal_reference_voltage, 0);
		stop_mode <= 1'b0;
		tick(6);
		chk(internal_reference_voltage, 1);
		$display("monitor done");
		bus(`REG_CLOCK_CTRL, 1, 32'h3E80);
		for (i = 0; i < 1400 && cpu_khz != 16'h3E80; i++) @(posedge ref_clk);
		tick(2);
		chk(flash_wait_states, 0);
		bus(`REG_CLOCK_CTRL, 1, 32'h7D00);
		tick(1000);
		chk(cpu_khz, 16'h3E80);
		for (i = 0; i < 400 && cpu_khz != 16'h7D00; i++) @(posedge ref_clk);
		tick(2);
		chk(flash_wait_states, 1);
		bus(`REG_CLOCK_CTRL, 1, 32'hFA0);
		tick(1300);
		chk(cpu_khz, 16'h7D00);
		bus(`REG_STATUS, 0, 0);
		chk(rdata & 32'h4, 32'h4);
		bus(`REG_CLOCK_CTRL, 1, 32'h3E80);
		for (i = 0; i < 1400 && cpu_khz != 16'h3E80; i++) @(posedge ref_clk);
		bus(`REG_CTRL, 1, 32'h2000);
		tick(2);
		chk(flash_wait_states, 1);
		tick(1300);
		bus(`REG_CTRL, 1, 32'h3000);
		tick(2);
		chk(cpu_khz, 16'h1068);
		chk(flash_wait_states, 0);
		low_supply <= 1'b1;
		tick(4);
		bus(`REG_CTRL, 1, 32'h1000);
		bus(`REG_CTRL, 0, 0);
		chk(rdata, 32'h3000);
		$display("clock done");
		strap <= 1'b0;
		por_above <= 1'b0;
		stored <= 8'h03;
		dly <= 8'h01;
		sys_rst <= 1'b1;
		tick(4);
		sys_rst <= 1'b0;
		tick(2);
		chk(chip_reset, 1);
		chk(brownout_enable, 0);
		por_above <= 1'b1;
		bor_above <= 1'b0;
		for (i = 0; i < 60 && !opt_load_req; i++) @(posedge ref_clk);
		chk(i >= 10 && i <= 16, 1);
		chk(chip_reset, 1);
		bor_above <= 1'b1;
		for (i = 0; i < 60 && chip_reset; i++) @(posedge ref_clk);
		tick(1);
		chk(chip_reset, 0);
		chk(brownout_threshold, 3);
		chk(brownout_enable, 1);
		$display("restart done");
		final_report;
	end
endmodule // tb
